/* File: hdl/bmd_decoder.sv */
// How it works
// - Window spans 20 bytes, 100 in banks 60-63.
// - Up to 80 RAM bytes follow the window.
// - Indirect pointers reach RAM linearly, bank ignored.
// - Offsets 70h-7Fh share one 16-byte common RAM.
// - Unimplemented locations read as zero.
// - Address: six bank bits, seven offset bits.
// - Sixty-four banks of 128 bytes each.
// - First 12 offsets of every bank are core registers.
`timescale 1ns/10ps
`default_nettype none

module bmd_decoder #(
  parameter int GPR_DEPTH = bmd_pkg::BMD_GPR_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic linear_i,
  input wire logic [bmd_pkg::BMD_BANK_W-1:0] bank_i,
  input wire logic [bmd_pkg::BMD_OFS_W-1:0] offset_i,
  input wire logic [bmd_pkg::BMD_ADDR_W-1:0] linear_addr_i,
  input wire logic [bmd_pkg::BMD_DATA_W-1:0] wdata_i,
  input wire logic [bmd_pkg::BMD_DATA_W-1:0] core_rdata_i,
  input wire logic [bmd_pkg::BMD_DATA_W-1:0] window_rdata_i,
  output logic core_sel_o,
  output logic window_sel_o,
  output logic ext_we_o,
  output logic [bmd_pkg::BMD_BANK_W-1:0] ext_bank_o,
  output logic [bmd_pkg::BMD_OFS_W-1:0] ext_offset_o,
  output logic [bmd_pkg::BMD_DATA_W-1:0] ext_wdata_o,
  output logic unmapped_o,
  output logic rvalid_o,
  output logic [bmd_pkg::BMD_DATA_W-1:0] rdata_o
);
  import bmd_pkg::*;

  // True for the banks whose long window leaves no room for RAM.
  function automatic logic long_window(input logic [5:0] bank);
    long_window = (bank >= BMD_LONG_WIN_FIRST_BANK);
  endfunction : long_window

  // First offset past the peripheral window of a bank.
  function automatic logic [6:0] window_end(input logic [5:0] bank);
    if (long_window(bank)) begin
      window_end = BMD_CORE_END + BMD_WIN_LONG_BYTES;
    end else begin
      window_end = BMD_CORE_END + BMD_WIN_SHORT_BYTES;
    end
  endfunction : window_end

  // Classifies a banked address into its region.
  function automatic bmd_region_t region_of(input logic [5:0] bank, input logic [6:0] ofs);
    logic [6:0] win_end;
    logic [7:0] ram_end;
    win_end = window_end(bank);
    // One bit wider, since in the long banks the sum would pass 7Fh and wrap.
    ram_end = {1'b0, win_end} + {1'b0, BMD_GPR_BYTES};
    if (ofs >= BMD_COMMON_BASE) begin
      region_of = BMD_RG_COMMON;
    end else if (ofs < BMD_CORE_END) begin
      region_of = BMD_RG_CORE;
    end else if (ofs < win_end) begin
      region_of = BMD_RG_WINDOW;
    end else if (!long_window(bank) && {1'b0, ofs} < ram_end) begin
      region_of = BMD_RG_GPR;
    end else begin
      region_of = BMD_RG_NONE;
    end
  endfunction : region_of

  // Linear RAM index of a banked RAM offset: bank times 80 plus the byte within.
  function automatic logic [12:0] gpr_index(input logic [5:0] bank, input logic [6:0] ofs);
    logic [12:0] base;
    base = 13'(bank) * 13'(BMD_GPR_BYTES);
    gpr_index = base + 13'(ofs - (BMD_CORE_END + BMD_WIN_SHORT_BYTES));
  endfunction : gpr_index

  // Banked and linear accesses share one RAM port, so both paths see the same bytes.
  bmd_gpr_if #(.AW(BMD_ADDR_W)) gpr ();

  bmd_gpr_ram #(
    .DEPTH(GPR_DEPTH),
    .AW(BMD_ADDR_W)
  ) u_gpr (
    .clk_i(clk_i),
    .port(gpr.host)
  );

  // Common RAM carries no reset, like the banked RAM, so a read before a write is unknown.
  logic [7:0] common_mem [BMD_COMMON_BYTES];
  logic [7:0] common_q;

  bmd_region_t region;
  bmd_region_t s1_region;
  bmd_region_t next_s1_region;
  logic s1_read;
  logic next_s1_read;
  logic [12:0] gpr_addr;
  logic [3:0] common_idx;
  logic common_we;
  logic common_re;

  logic next_core_sel;
  logic next_window_sel;
  logic next_ext_we;
  logic [5:0] next_ext_bank;
  logic [6:0] next_ext_offset;
  logic [7:0] next_ext_wdata;
  logic next_unmapped;
  logic next_rvalid;
  logic [7:0] next_rdata;

  // Stage 0: decode the request that arrives this cycle.
  always_comb begin
    region = region_of(bank_i, offset_i);
    gpr_addr = gpr_index(bank_i, offset_i);
    if (linear_i) begin
      // The linear path ignores the selected bank altogether.
      // Its limit is fixed; a larger RAM depth would need a new limit as well.
      gpr_addr = linear_addr_i;
      region = (linear_addr_i <= BMD_GPR_LAST) ? BMD_RG_GPR : BMD_RG_NONE;
    end
    common_idx = offset_i[3:0];
    gpr.en = req_i && (region == BMD_RG_GPR);
    gpr.we = we_i;
    gpr.addr = gpr_addr;
    gpr.wdata = wdata_i;
  end

  // Common RAM strobes; only offsets 70h-7Fh reach them, whatever the bank.
  always_comb begin
    common_we = req_i && (region == BMD_RG_COMMON) && we_i;
    common_re = req_i && (region == BMD_RG_COMMON) && !we_i;
  end

  // Common RAM is one array whatever the bank, so every bank sees the same bytes.
  always_ff @(posedge clk_i) begin
    if (common_we) begin
      common_mem[common_idx] <= wdata_i;
    end
    if (common_re) begin
      common_q <= common_mem[common_idx];
    end
  end

  // Stage 1 strobes to core and window logic.
  always_comb begin
    next_s1_region = req_i ? region : BMD_RG_NONE;
    next_s1_read = req_i && !we_i;
    next_core_sel = req_i && (region == BMD_RG_CORE);
    next_window_sel = req_i && (region == BMD_RG_WINDOW);
    next_ext_we = req_i && we_i && (region == BMD_RG_CORE || region == BMD_RG_WINDOW);
    next_unmapped = req_i && (region == BMD_RG_NONE);
  end

  // Copies for the core and window logic follow the inputs every cycle, request or not.
  always_comb begin
    next_ext_bank = bank_i;
    next_ext_offset = offset_i;
    next_ext_wdata = wdata_i;
  end

  // Stage 2 returns read data; zero outside a read keeps stale bytes off the bus.
  always_comb begin
    next_rvalid = s1_read;
    unique case (s1_region)
      BMD_RG_CORE: next_rdata = core_rdata_i;
      BMD_RG_WINDOW: next_rdata = window_rdata_i;
      BMD_RG_GPR: next_rdata = gpr.rdata;
      BMD_RG_COMMON: next_rdata = common_q;
      BMD_RG_NONE: next_rdata = BMD_RDATA_RST;
      default: next_rdata = BMD_RDATA_RST;
    endcase
    if (!s1_read) begin
      next_rdata = BMD_RDATA_RST;
    end
  end

  // Strobes are registered so every output of the block starts at a flip-flop.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_region <= BMD_RG_NONE;
      s1_read <= 1'b0;
      core_sel_o <= 1'b0;
      window_sel_o <= 1'b0;
      ext_we_o <= 1'b0;
      unmapped_o <= 1'b0;
    end else begin
      s1_region <= next_s1_region;
      s1_read <= next_s1_read;
      core_sel_o <= next_core_sel;
      window_sel_o <= next_window_sel;
      ext_we_o <= next_ext_we;
      unmapped_o <= next_unmapped;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_bank_o <= BMD_BANK_RST;
      ext_offset_o <= BMD_OFS_RST;
      ext_wdata_o <= BMD_RDATA_RST;
    end else begin
      ext_bank_o <= next_ext_bank;
      ext_offset_o <= next_ext_offset;
      ext_wdata_o <= next_ext_wdata;
    end
  end

  // Core and window data are taken one cycle after the select, so that logic has a
  // full cycle to answer from the registered bank and offset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= BMD_RDATA_RST;
    end else begin
      rvalid_o <= next_rvalid;
      rdata_o <= next_rdata;
    end
  end
endmodule : bmd_decoder

`default_nettype wire

/* File: hdl/bmd_gpr_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface bmd_gpr_if #(
  parameter int AW = 13
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport host (output en, output we, output addr, output wdata, input rdata);
  modport ram (input en, input we, input addr, input wdata, output rdata);
endinterface : bmd_gpr_if

`default_nettype wire

/* File: hdl/bmd_gpr_ram.sv */
`timescale 1ns/10ps
`default_nettype none

module bmd_gpr_ram #(
  parameter int DEPTH = 4800,
  parameter int AW = 13
) (
  input wire logic clk_i,
  bmd_gpr_if.ram port
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_q;

  // Storage carries no reset; contents are undefined until written.
  always_ff @(posedge clk_i) begin
    if (port.en && port.we) begin
      mem[port.addr] <= port.wdata;
    end
    if (port.en && !port.we) begin
      rdata_q <= mem[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule : bmd_gpr_ram

`default_nettype wire

/* File: hdl/bmd_pkg.sv */
package bmd_pkg;

  localparam int BMD_DATA_W = 8;
  localparam int BMD_ADDR_W = 13;
  localparam int BMD_BANK_W = 6;
  localparam int BMD_OFS_W = 7;
  localparam int BMD_BANKS = 64;
  localparam int BMD_BANK_BYTES = 128;

  // Offsets inside one bank.
  localparam logic [6:0] BMD_CORE_END = 7'h0C;
  localparam logic [6:0] BMD_WIN_SHORT_BYTES = 7'h14;
  localparam logic [6:0] BMD_WIN_LONG_BYTES = 7'h64;
  localparam logic [5:0] BMD_LONG_WIN_FIRST_BANK = 6'h3C;
  localparam logic [6:0] BMD_GPR_BYTES = 7'h50;
  localparam logic [6:0] BMD_COMMON_BASE = 7'h70;
  localparam int BMD_COMMON_BYTES = 16;

  // General purpose RAM seen as one linear space.
  localparam int BMD_GPR_BANKS = 60;
  localparam int BMD_GPR_DEPTH = 4800;
  localparam logic [12:0] BMD_GPR_LAST = 13'h12BF;

  // Values after reset.
  localparam logic [7:0] BMD_RDATA_RST = 8'h00;
  localparam logic [5:0] BMD_BANK_RST = 6'h00;
  localparam logic [6:0] BMD_OFS_RST = 7'h00;

  typedef enum logic [2:0] {
    BMD_RG_NONE,
    BMD_RG_CORE,
    BMD_RG_WINDOW,
    BMD_RG_GPR,
    BMD_RG_COMMON
  } bmd_region_t;

endpackage : bmd_pkg

/* File: verification/bmd_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bmd_core_model (
  input wire logic clk_i,
  input wire logic core_sel_i,
  input wire logic window_sel_i,
  input wire logic [5:0] ext_bank_i,
  input wire logic [6:0] ext_offset_i,
  output logic [7:0] core_rdata_o,
  output logic [7:0] window_rdata_o
);
  logic [7:0] junk = 8'h00;
  always @(posedge clk_i) junk <= junk + 8'h35;
  // Unselected sources show a moving pattern so a stale byte cannot pass.
  assign core_rdata_o = core_sel_i ? {1'b1, ext_offset_i} : junk;
  assign window_rdata_o = window_sel_i ? {ext_bank_i[0], ext_offset_i} ^ 8'h5A : ~junk;
endmodule : bmd_core_model
`default_nettype wire

/* File: verification/bmd_props.sv */
`timescale 1ns/10ps
`default_nettype none
module bmd_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic linear_i,
  input wire logic [5:0] bank_i,
  input wire logic [6:0] offset_i,
  input wire logic [12:0] linear_addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic core_sel_o,
  input wire logic window_sel_o,
  input wire logic ext_we_o,
  input wire logic [5:0] ext_bank_o,
  input wire logic [6:0] ext_offset_o,
  input wire logic [7:0] ext_wdata_o,
  input wire logic unmapped_o,
  input wire logic rvalid_o,
  input wire logic [7:0] rdata_o
);
  logic bk;
  logic bad;
  assign bk = req_i && !linear_i;
  assign bad = req_i && linear_i && linear_addr_i > 13'h12BF;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_core; bk && offset_i < 7'h0C |=> core_sel_o && !window_sel_o; endproperty
  a_core: assert property (p_core) else $error("core miss");
  property p_win; bk && offset_i > 7'h0B
    && (offset_i < 7'h20 || bank_i > 6'h3B && offset_i < 7'h70) |=> window_sel_o; endproperty
  a_win: assert property (p_win) else $error("window miss");
  property p_ram; bk && bank_i < 6'h3C && offset_i inside {[7'h20:7'h6F]}
    |=> !(core_sel_o || window_sel_o || unmapped_o); endproperty
  a_ram: assert property (p_ram) else $error("ram misrouted");
  property p_com; bk && offset_i > 7'h6F |=> !(core_sel_o || window_sel_o || unmapped_o);
  endproperty
  a_com: assert property (p_com) else $error("common misrouted");
  property p_lin; req_i && linear_i |=> !core_sel_o && !window_sel_o
    && unmapped_o == ($past(linear_addr_i) > 13'h12BF); endproperty
  a_lin: assert property (p_lin) else $error("linear misrouted");
  property p_zero; bad && !we_i |-> ##2 rvalid_o && rdata_o == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  property p_drop; bad && we_i |=> unmapped_o && !ext_we_o ##1 !rvalid_o; endproperty
  a_drop: assert property (p_drop) else $error("unmapped write acted");
  property p_bank; bk |=> ext_bank_o == $past(bank_i); endproperty
  a_bank: assert property (p_bank) else $error("bank copy wrong");
  property p_rd; req_i && !we_i |-> ##2 rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  property p_ext; bk && we_i && offset_i < 7'h20 |=> ext_we_o
    && ext_wdata_o == $past(wdata_i) && ext_offset_o == $past(offset_i); endproperty
  a_ext: assert property (p_ext) else $error("register write not passed on");
  property p_noext; req_i && we_i && (linear_i || bank_i < 6'h3C && offset_i > 7'h1F)
    |=> !ext_we_o; endproperty
  a_noext: assert property (p_noext) else $error("ram write leaked out");
endmodule : bmd_props
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic linear_i = 1'b0;
  logic [5:0] bank_i = 6'h00;
  logic [6:0] offset_i = 7'h00;
  logic [12:0] linear_addr_i = 13'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] core_rdata_i, window_rdata_i, ext_wdata_o, rdata_o, d;
  logic core_sel_o, window_sel_o, ext_we_o, unmapped_o, rvalid_o;
  logic [5:0] ext_bank_o, b;
  logic [6:0] ext_offset_o, o;
  int n_fail = 0;
  int n_compared = 0;
  int i;
  always #12.5 clk_i = ~clk_i;
  bmd_decoder u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .we_i(we_i),
    .linear_i(linear_i), .bank_i(bank_i), .offset_i(offset_i), .linear_addr_i(linear_addr_i),
    .wdata_i(wdata_i), .core_rdata_i(core_rdata_i), .window_rdata_i(window_rdata_i),
    .core_sel_o(core_sel_o), .window_sel_o(window_sel_o), .ext_we_o(ext_we_o),
    .ext_bank_o(ext_bank_o), .ext_offset_o(ext_offset_o), .ext_wdata_o(ext_wdata_o),
    .unmapped_o(unmapped_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o));
  bmd_core_model u_core (.clk_i(clk_i), .core_sel_i(core_sel_o), .window_sel_i(window_sel_o),
    .ext_bank_i(ext_bank_o), .ext_offset_i(ext_offset_o), .core_rdata_o(core_rdata_i),
    .window_rdata_o(window_rdata_i));
  function automatic logic [12:0] li(input logic [5:0] bk, input logic [6:0] of);
    return 13'(bk) * 13'h0050 + 13'(of) - 13'h0020;
  endfunction : li
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input logic w, input logic l, input logic [5:0] bk, input logic [6:0] of,
      input logic [12:0] la, input logic [7:0] wd);
    @(posedge clk_i);
    req_i <= 1'b1;
    we_i <= w;
    linear_i <= l;
    bank_i <= bk;
    offset_i <= of;
    linear_addr_i <= la;
    wdata_i <= wd;
  endtask : go
  // Idles the request, then checks the strobes and the read answer.
  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    @(posedge clk_i);
    req_i <= 1'b0;
    #1;
    chk({5'h00, core_sel_o, window_sel_o, unmapped_o}, {5'h00, sel});
    @(posedge clk_i);
    #1;
    chk({rvalid_o, rdata_o[6:0]}, {1'b1, exp[6:0]});
    chk(rdata_o, exp);
  endtask : rd
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'hB7DDF07C));
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 12; i++) begin
      go(1'b0, 1'b0, 6'($urandom), 7'(i), 13'h0000, 8'h00);
      rd(3'b100, {1'b1, 7'(i)});
    end
    $display("core test done");
    for (i = 0; i < 40; i++) begin
      b = (i < 20) ? 6'($urandom_range(59)) : 6'($urandom_range(63, 60));
      o = (i < 20) ? 7'($urandom_range(31, 12)) : 7'($urandom_range(111, 12));
      go(1'b1, 1'b0, b, o, 13'h0000, 8'hFF);
      go(1'b0, 1'b0, b, o, 13'h0000, 8'h00);
      rd(3'b010, {b[0], o} ^ 8'h5A);
    end
    $display("window test done");
    for (i = 0; i < 40; i++) begin
      b = (i == 0) ? 6'h3B : 6'($urandom_range(59));
      o = (i == 0) ? 7'h6F : 7'($urandom_range(111, 32));
      d = 8'($urandom);
      go(1'b1, 1'b0, b, o, 13'h0000, d);
      go(1'b0, 1'b1, 6'h3F, 7'h00, li(b, o), 8'h00);
      rd(3'b000, d);
      go(1'b1, 1'b1, 6'h00, 7'h00, li(b, o), ~d);
      go(1'b0, 1'b0, b, o, 13'h0000, 8'h00);
      rd(3'b000, ~d);
    end
    $display("ram test done");
    go(1'b1, 1'b1, 6'h00, 7'h00, 13'h12BF, 8'h3C);
    go(1'b1, 1'b1, 6'h00, 7'h00, 13'h12C0, 8'hC3);
    go(1'b0, 1'b1, 6'h00, 7'h00, 13'h12C0, 8'h00);
    rd(3'b001, 8'h00);
    go(1'b1, 1'b1, 6'h00, 7'h00, 13'h1FFF, 8'hC3);
    go(1'b0, 1'b1, 6'h00, 7'h00, 13'h12BF, 8'h00);
    rd(3'b000, 8'h3C);
    $display("unmapped test done");
    for (i = 0; i < 16; i++) begin
      d = 8'($urandom);
      go(1'b1, 1'b0, 6'($urandom), 7'h70 + 7'(i), 13'h0000, d);
      go(1'b0, 1'b0, 6'($urandom), 7'h70 + 7'(i), 13'h0000, 8'h00);
      rd(3'b000, d);
    end
    $display("common test done");
    final_report;
  end
  initial begin
    #100us;
    n_fail++;
    final_report;
  end
endmodule : tb
bind bmd_decoder bmd_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .we_i(we_i), .linear_i(linear_i), .bank_i(bank_i), .offset_i(offset_i),
  .linear_addr_i(linear_addr_i), .wdata_i(wdata_i), .core_sel_o(core_sel_o),
  .window_sel_o(window_sel_o), .ext_we_o(ext_we_o), .ext_bank_o(ext_bank_o),
  .ext_offset_o(ext_offset_o), .ext_wdata_o(ext_wdata_o), .unmapped_o(unmapped_o),
  .rvalid_o(rvalid_o), .rdata_o(rdata_o));
`default_nettype wire
